// [rtl/cfg_info_map.svh]
`ifndef CFG_INFO_MAP_SVH
`define CFG_INFO_MAP_SVH
// Index pointer values for fuse and lock reads
`define CIR_IDX_LOW_FUSE 16'h0000
`define CIR_IDX_LOCK 16'h0001
`define CIR_IDX_EXT_FUSE 16'h0002
`define CIR_IDX_HIGH_FUSE 16'h0003
// Signature table byte addresses
`define CIR_TBL_SIG0 6'h00
`define CIR_TBL_FAST_CAL 6'h01
`define CIR_TBL_SIG1 6'h02
`define CIR_TBL_TEMP_A 6'h03
`define CIR_TBL_SIG2 6'h04
`define CIR_TBL_TEMP_B 6'h05
`define CIR_TBL_RSVD 6'h06
`define CIR_TBL_SLOW_CAL 6'h07
`define CIR_TBL_TS_GAIN 6'h2C
`define CIR_TBL_TS_OFFS 6'h2D
`define CIR_TBL_BYTES 7'h40
// Window lengths in CPU cycles
`define CIR_LOAD_WINDOW 2'h3
`define CIR_STORE_WINDOW 3'h4
// Flash and EEPROM geometry
`define CIR_FLASH_PAGES 8'h80
`define CIR_FLASH_PAGE_WORDS 6'h20
`define CIR_EE_PAGES 7'h40
`define CIR_EE_PAGE_BYTES 3'h4
// Reset values
`define CIR_BYTE_ERASED 8'hFF
`define CIR_BYTE_ZERO 8'h00
`define CIR_LOCK_UNUSED 2'h3
`endif

// [rtl/cir_pkg.sv]
package cir_pkg;
  typedef enum logic [1:0] {CIR_IDLE, CIR_ARMED} cir_state_e;
  typedef struct packed {
    logic [7:0] sig0;
    logic [7:0] sig1;
    logic [7:0] sig2;
  } cir_sig_s;
  typedef struct packed {
    logic [6:0] page_select_bits;
    logic [4:0] word_in_page_bits;
  } cir_flash_addr_s;
  typedef struct packed {
    logic [5:0] page;
    logic [1:0] byte_sel;
  } cir_eeprom_addr_s;
endpackage

// [rtl/cir_unit.sv]
// Functional notes
// - Core reads the signature table by byte; programmers use word addresses.
// - Bytes 0x00-0x07 hold signature, oscillator and temperature trims.
// - Sensor gain at 0x2C, offset at 0x2D; other words reserved.
// - Gain byte unsigned fixed point over 128; offset byte signed.
// - Three signature bytes readable externally even when locked.
// - During reset, oscillator trims load from stored calibration bytes.
// - Fuse and lock reads give zero programmed, one unprogrammed.
// - Load within three cycles after select returns fuse or lock data.
// - Selects auto-clear after read, three cycles without load, four without store; here the three-cycle timeout always clears them first.
// - Lock read at index 0x0001: boot locks 5..2, general locks 1..0.
// - Fuse reads at 0x0000 low, 0x0003 high, 0x0002 extended.
// - Signature read select plus enable, then load returns table byte.
// - Flash is 128 pages of 32 words, PC[4:0] word, PC[11:5] page.
// - EEPROM is 64 pages of 4 bytes, address[1:0] byte, [7:2] page.
`include "cfg_info_map.svh"
`timescale 1ns/100ps
`default_nettype none
module cir_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control register write from the core
  input wire logic ctrl_wr,
  input wire logic fuse_lock_read_select,
  input wire logic signature_read_select,
  input wire logic self_program_enable,
  input wire logic program_memory_store_instr,
  // Load instruction request
  input wire logic load_req,
  input wire logic [15:0] index_ptr,
  input wire logic [7:0] flash_rdata,
  // Stored nonvolatile contents (0 = programmed)
  input wire logic [7:0] low_fuse_byte,
  input wire logic [7:0] high_fuse_byte,
  input wire logic [7:0] extended_fuse_byte,
  input wire logic [5:0] lock_bits,
  input wire logic [7:0] tbl_fast_cal,
  input wire logic [7:0] tbl_slow_cal,
  input wire logic [7:0] tbl_temp_a,
  input wire logic [7:0] tbl_temp_b,
  input wire logic [7:0] tbl_ts_gain,
  input wire logic [7:0] tbl_ts_offs,
  input wire cir_pkg::cir_sig_s sig_bytes,
  // External programmer word read
  input wire logic [5:0] ext_word_addr,
  // Results
  output logic [7:0] load_data,
  output logic load_valid,
  output logic [15:0] ext_word_data,
  output logic [7:0] fast_osc_trim,
  output logic [7:0] slow_osc_trim,
  output logic [7:0] fast_osc_temp_trim_a,
  output logic [7:0] fast_osc_temp_trim_b,
  output logic sel_fuse_lock,
  output logic sel_sig,
  output logic spm_enable,
  // Geometry split of addresses
  input wire logic [11:0] pc_addr,
  input wire logic [7:0] eeprom_addr,
  output cir_pkg::cir_flash_addr_s flash_addr,
  output cir_pkg::cir_eeprom_addr_s ee_addr
);
  // Select state
  cir_pkg::cir_state_e state_q, state_d;
  logic fl_q, fl_d;
  logic sg_q, sg_d;
  logic en_q, en_d;
  logic [2:0] cnt_q, cnt_d;
  // Load result
  logic [7:0] ld_q, ld_d;
  logic lv_q, lv_d;
  // Programmer word view
  logic [15:0] ew_q, ew_d;
  logic [5:0] ew_even, ew_odd;
  // Oscillator and temperature trims
  logic [7:0] f0_q, f0_d;
  logic [7:0] f1_q, f1_d;
  logic [7:0] ta_q, ta_d;
  logic [7:0] tb_q, tb_d;
  // Address split
  cir_pkg::cir_flash_addr_s fa_q, fa_d;
  cir_pkg::cir_eeprom_addr_s ea_q, ea_d;
  // Decode helpers
  logic win_open;
  logic [7:0] fl_byte;

  // Byte-addressed table lookup for the core
  // Reserved and unmapped bytes read as erased, like blank flash
  function automatic logic [7:0] tbl_byte(input logic [5:0] a);
    logic [7:0] r;
    r = `CIR_BYTE_ERASED;
    if (a == `CIR_TBL_SIG0) begin
      r = sig_bytes.sig0;
    end else if (a == `CIR_TBL_FAST_CAL) begin
      r = tbl_fast_cal;
    end else if (a == `CIR_TBL_SIG1) begin
      r = sig_bytes.sig1;
    end else if (a == `CIR_TBL_TEMP_A) begin
      r = tbl_temp_a;
    end else if (a == `CIR_TBL_SIG2) begin
      r = sig_bytes.sig2;
    end else if (a == `CIR_TBL_TEMP_B) begin
      r = tbl_temp_b;
    end else if (a == `CIR_TBL_SLOW_CAL) begin
      r = tbl_slow_cal;
    end else if (a == `CIR_TBL_TS_GAIN) begin
      r = tbl_ts_gain;
    end else if (a == `CIR_TBL_TS_OFFS) begin
      r = tbl_ts_offs;
    end
    return r;
  endfunction

  // Special load window: armed cycles 0 to 2 only
  // A load after that is an ordinary flash read
  always_comb begin
    win_open = (state_q == cir_pkg::CIR_ARMED) && (cnt_q < 3'(`CIR_LOAD_WINDOW));
  end

  // lock layout
  // Stored bits pass unchanged, so a programmed bit reads zero
  always_comb begin
    fl_byte = `CIR_BYTE_ERASED;
    if (index_ptr == `CIR_IDX_LOCK) begin
      fl_byte = {`CIR_LOCK_UNUSED, lock_bits};
    end else if (index_ptr == `CIR_IDX_HIGH_FUSE) begin
      fl_byte = high_fuse_byte;
    end else if (index_ptr == `CIR_IDX_EXT_FUSE) begin
      fl_byte = extended_fuse_byte;
    end else if (index_ptr == `CIR_IDX_LOW_FUSE) begin
      fl_byte = low_fuse_byte;
    end
  end

  // Select state: armed by a control write, cleared by use or timeout
  always_comb begin
    state_d = state_q;
    fl_d = fl_q;
    sg_d = sg_q;
    en_d = en_q;
    cnt_d = cnt_q;
    case (state_q)
      cir_pkg::CIR_IDLE: begin
        // A write without enable or without a select is ignored
        if (ctrl_wr && self_program_enable
            && (fuse_lock_read_select || signature_read_select)) begin
          state_d = cir_pkg::CIR_ARMED;
          fl_d = fuse_lock_read_select;
          // Fuse and lock read wins when firmware sets both selects
          sg_d = signature_read_select && !fuse_lock_read_select;
          en_d = 1'b1;
          cnt_d = 3'h0;
        end
      end
      cir_pkg::CIR_ARMED: begin
        cnt_d = cnt_q + 3'h1;
        // auto clear
        // Store timeout kept for completeness; the shorter load timeout fires first
        if ((load_req && win_open)
            || cnt_q + 3'h1 >= 3'(`CIR_LOAD_WINDOW)
            || (cnt_q + 3'h1 >= `CIR_STORE_WINDOW && !program_memory_store_instr)) begin
          state_d = cir_pkg::CIR_IDLE;
          fl_d = 1'b0;
          sg_d = 1'b0;
          en_d = 1'b0;
        end
      end
      default: begin
        state_d = cir_pkg::CIR_IDLE;
      end
    endcase
  end

  // Load result: one-cycle valid pulse, data held until the next load
  always_comb begin
    ld_d = ld_q;
    lv_d = 1'b0;
    if (load_req && win_open) begin
      lv_d = 1'b1;
      if (sg_q) begin
        ld_d = tbl_byte(index_ptr[5:0]);
      end else begin
        ld_d = fl_byte;
      end
    end else if (load_req) begin
      ld_d = flash_rdata;
      lv_d = 1'b1;
    end
  end

  // word view for programmers, readable regardless of lock
  always_comb begin
    ew_even = {ext_word_addr[4:0], 1'b0};
    ew_odd = {ext_word_addr[4:0], 1'b1};
    // Word n pairs byte 2n low with byte 2n+1 high
    ew_d = {tbl_byte(ew_odd), tbl_byte(ew_even)};
    // Words past the table read as erased
    if (ext_word_addr[5]) begin
      ew_d = {`CIR_BYTE_ERASED, `CIR_BYTE_ERASED};
    end
  end

  // trims track stored bytes while held in reset
  // Copy runs on every clock edge while in reset, so even a one-cycle reset loads the trims
  always_comb begin
    f0_d = f0_q;
    f1_d = f1_q;
    ta_d = ta_q;
    tb_d = tb_q;
    if (!rst_b) begin
      f0_d = tbl_fast_cal;
      f1_d = tbl_slow_cal;
      ta_d = tbl_temp_a;
      tb_d = tbl_temp_b;
    end
  end

  // address split
  // Registered so both split addresses come straight from flip-flops
  always_comb begin
    fa_d = cir_pkg::cir_flash_addr_s'(pc_addr);
    ea_d = cir_pkg::cir_eeprom_addr_s'(eeprom_addr);
  end

  // Control group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= cir_pkg::CIR_IDLE;
      fl_q <= 1'b0;
      sg_q <= 1'b0;
      en_q <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      fl_q <= fl_d;
      sg_q <= sg_d;
      en_q <= en_d;
      cnt_q <= cnt_d;
    end
  end

  // Load result group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ld_q <= `CIR_BYTE_ZERO;
      lv_q <= 1'b0;
    end else begin
      ld_q <= ld_d;
      lv_q <= lv_d;
    end
  end

  // Programmer word view
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ew_q <= {`CIR_BYTE_ZERO, `CIR_BYTE_ZERO};
    end else begin
      ew_q <= ew_d;
    end
  end

  // Trims have no reset branch: reset is exactly when they must load
  always_ff @(posedge clk) begin
    f0_q <= f0_d;
    f1_q <= f1_d;
    ta_q <= ta_d;
    tb_q <= tb_d;
  end

  // Address split group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fa_q <= '0;
      ea_q <= '0;
    end else begin
      fa_q <= fa_d;
      ea_q <= ea_d;
    end
  end

  // Every output is a register copy
  assign load_data = ld_q;
  assign load_valid = lv_q;
  assign ext_word_data = ew_q;
  assign fast_osc_trim = f0_q;
  assign slow_osc_trim = f1_q;
  assign fast_osc_temp_trim_a = ta_q;
  assign fast_osc_temp_trim_b = tb_q;
  assign sel_fuse_lock = fl_q;
  assign sel_sig = sg_q;
  assign spm_enable = en_q;
  assign flash_addr = fa_q;
  assign ee_addr = ea_q;
endmodule
`default_nettype wire

// [test/cir_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cir_core_model (
  // Clock
  input wire logic clk,
  // Core requests
  output logic ctrl_wr,
  output logic fuse_lock_read_select,
  output logic signature_read_select,
  output logic self_program_enable,
  output logic program_memory_store_instr,
  output logic load_req,
  output logic [15:0] index_ptr,
  output logic [7:0] flash_rdata
);
  // Flash stand-in pattern, distinct from table paths
  assign flash_rdata = index_ptr[7:0] ^ 8'hA5;
  initial begin
    {fuse_lock_read_select, signature_read_select, self_program_enable, ctrl_wr} = '0;
    program_memory_store_instr = 1'b0;
    load_req = 1'b0;
    index_ptr = '0;
  end
  task automatic arm(input bit fl, input bit sg);
    {fuse_lock_read_select, signature_read_select, self_program_enable, ctrl_wr} = {fl, sg, 2'b11};
    @(negedge clk);
    {fuse_lock_read_select, signature_read_select} = {!fl, !sg};
    {self_program_enable, ctrl_wr} = 2'b00;
  endtask
  task automatic load(input logic [15:0] x);
    index_ptr = x;
    load_req = 1'b1;
    @(negedge clk);
    load_req = 1'b0;
    index_ptr = ~x;
  endtask
endmodule
`default_nettype wire

// [test/cir_unit_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module cir_unit_chk (
  // Inputs
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ctrl_wr,
  input wire logic fuse_lock_read_select,
  input wire logic signature_read_select,
  input wire logic self_program_enable,
  input wire logic load_req,
  input wire logic [15:0] index_ptr,
  input wire logic [7:0] flash_rdata,
  input wire logic [5:0] lock_bits,
  input wire logic [7:0] tbl_fast_cal,
  input wire logic [11:0] pc_addr,
  // Outputs
  input wire logic [7:0] load_data,
  input wire logic load_valid,
  input wire logic sel_fuse_lock,
  input wire logic sel_sig,
  input wire logic spm_enable,
  input wire logic [7:0] fast_osc_trim,
  input wire cir_pkg::cir_flash_addr_s flash_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  load_answer_a: assert property (load_req |=> load_valid)
    else $error("load not answered");
  arm_select_a: assert property (ctrl_wr && self_program_enable && fuse_lock_read_select
    |=> sel_fuse_lock && spm_enable) else $error("arming ignored");
  auto_clear_a: assert property ($rose(spm_enable) |-> ##[1:3] !spm_enable)
    else $error("enable not cleared");
  arm_sig_a: assert property (ctrl_wr && self_program_enable && signature_read_select
    && !fuse_lock_read_select && !spm_enable |=> sel_sig && spm_enable && !sel_fuse_lock)
    else $error("signature arming ignored");
  lock_read_a: assert property (load_req && sel_fuse_lock && spm_enable
    && index_ptr == 16'h0001 |=> load_data == {2'b11, $past(lock_bits)})
    else $error("lock byte wrong");
  sig_read_a: assert property (load_req && sel_sig && !sel_fuse_lock && spm_enable
    && index_ptr == 16'h0001 |=> load_data == $past(tbl_fast_cal)) else $error("table byte wrong");
  plain_load_a: assert property (load_req && !spm_enable
    |=> load_data == $past(flash_rdata)) else $error("flash byte wrong");
  trim_load_a: assert property ($rose(rst_b) |-> fast_osc_trim == $past(tbl_fast_cal))
    else $error("trim not loaded");
  page_split_a: assert property ($past(rst_b) |-> flash_addr == $past(pc_addr))
    else $error("flash split wrong");
endmodule
bind cir_unit cir_unit_chk i_chk (.*);
`default_nettype wire

// [test/test_config_info_read_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module test_config_info_read_unit;
  logic clk, rst_b, ctrl_wr, fuse_lock_read_select, signature_read_select, self_program_enable;
  logic program_memory_store_instr, load_req, load_valid, sel_fuse_lock, sel_sig, spm_enable;
  logic [15:0] index_ptr, ext_word_data, e;
  logic [7:0] flash_rdata, low_fuse_byte, high_fuse_byte, extended_fuse_byte, tbl_fast_cal;
  logic [7:0] tbl_slow_cal, tbl_temp_a, tbl_temp_b, tbl_ts_gain, tbl_ts_offs, load_data;
  logic [7:0] fast_osc_trim, slow_osc_trim, fast_osc_temp_trim_a, fast_osc_temp_trim_b;
  logic [7:0] eeprom_addr;
  logic [5:0] lock_bits, ext_word_addr;
  logic [11:0] pc_addr;
  cir_pkg::cir_sig_s sig_bytes;
  cir_pkg::cir_flash_addr_s flash_addr;
  cir_pkg::cir_eeprom_addr_s ee_addr;
  int tbl[64];
  int q[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 44, 45, 16};
  int w[$] = '{0, 1, 2, 3, 22, 32, 63};
  int mismatches = 0;
  int checks_done = 0;
  cir_unit i_dut (.*);
  cir_core_model i_core (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [7:0] ex(input bit fl, input int d, input int x);
    if (d > 3) return 8'(x) ^ 8'hA5;
    if (!fl) return 8'(tbl[x]);
    case (x)
      0: return low_fuse_byte;
      1: return {2'b11, lock_bits};
      2: return extended_fuse_byte;
      3: return high_fuse_byte;
      default: return 8'hFF;
    endcase
  endfunction
  // Load at cycle d after arming; beyond three cycles it must be a plain flash read
  task automatic rd(input bit fl, input int d, input int x);
    i_core.arm(fl, !fl);
    repeat (d - 1) @(negedge clk);
    i_core.load(16'(x));
    chk("load_valid", load_valid, 1);
    chk("load_data", load_data, ex(fl, d, x));
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    ext_word_addr = '0;
    void'($urandom(21923));
    {low_fuse_byte, high_fuse_byte, extended_fuse_byte, tbl_fast_cal} = $urandom;
    {tbl_slow_cal, tbl_temp_a, tbl_temp_b, tbl_ts_gain} = $urandom;
    {tbl_ts_offs, sig_bytes} = $urandom;
    {lock_bits, pc_addr, eeprom_addr} = 26'($urandom);
    foreach (tbl[i]) tbl[i] = 255;
    tbl[0] = sig_bytes.sig0;
    tbl[1] = tbl_fast_cal;
    tbl[2] = sig_bytes.sig1;
    tbl[3] = tbl_temp_a;
    tbl[4] = sig_bytes.sig2;
    tbl[5] = tbl_temp_b;
    tbl[7] = tbl_slow_cal;
    tbl[44] = tbl_ts_gain;
    tbl[45] = tbl_ts_offs;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("trims", {fast_osc_trim, slow_osc_trim}, {tbl_fast_cal, tbl_slow_cal});
    chk("temp_trim_a", fast_osc_temp_trim_a, tbl_temp_a);
    chk("temp_trim_b", fast_osc_temp_trim_b, tbl_temp_b);
    for (int i = 0; i < 5; i++) begin
      rd(1, i % 3 + 1, i);
    end
    foreach (q[i]) begin
      rd(0, i % 3 + 1, q[i]);
    end
    rd(1, 4, 1);
    chk("sel_fuse_lock", sel_fuse_lock, 0);
    chk("spm_enable", spm_enable, 0);
    rd(0, 4, 44);
    chk("sel_sig", sel_sig, 0);
    foreach (w[i]) begin
      ext_word_addr = 6'(w[i]);
      {pc_addr, eeprom_addr} = 20'($urandom);
      e = (w[i] < 32) ? {8'(tbl[2 * w[i] + 1]), 8'(tbl[2 * w[i]])} : 16'hFFFF;
      @(negedge clk);
      chk("ext_word", ext_word_data, e);
      chk("ee_addr", ee_addr, eeprom_addr);
      chk("flash_addr", flash_addr, pc_addr);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
